// [hw/ufr_top.sv]
// user nonvolatile byte store: fabric read port and serial programming port
// How it works
// RL1 - eight banks of 128 bits, bank-wide erase
// RL2 - one byte per access, synchronous to clk_sys
// RL3 - fabric gives 7-bit bank and byte address
// RL4 - top three bits bank, low four byte
// RL5 - only the programming port changes contents
// RL6 - read back over programming port or fabric
// RL7 - erase, write, optional on-chip decrypted write
// RL8 - byte appears next edge; address held stable
`timescale 1ns/1ps
module ufr_top import ufr_pkg::*; #(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // fabric read port
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data,
  // serial programming port pins
  input wire logic tap_clk,
  input wire logic tap_sel,
  input wire logic tap_din,
  output logic tap_dout,
  // status
  output logic prog_busy
);
  logic [SYNC_W-1:0] s1_r;
  logic [SYNC_W-1:0] s2_r;
  logic [SYNC_W-1:0] s3_r;
  logic [SYNC_W-1:0] filt_r;
  logic [SYNC_W-1:0] filt_nxt;
  logic tclk_d_r;
  logic tsel_d_r;
  logic [FRAME_BITS-1:0] frame_r;
  logic [FRAME_BITS-1:0] frame_nxt;
  logic [4:0] bits_r;
  logic [4:0] bits_nxt;
  logic [DW-1:0] out_r;
  logic [DW-1:0] out_nxt;
  logic tap_dout_r;
  logic tap_dout_nxt;
  logic rdbk_pend_r;
  logic rdbk_pend_nxt;
  ufr_state_t st_r;
  ufr_state_t st_nxt;
  logic [BANK_W-1:0] bank_r;
  logic [BANK_W-1:0] bank_nxt;
  logic [BYTE_W-1:0] cnt_r;
  logic [BYTE_W-1:0] cnt_nxt;
  logic [DW-1:0] key_r;
  logic [DW-1:0] key_nxt;
  logic busy_r;
  logic busy_nxt;
  logic tclk_rise;
  logic sel_fall;
  logic frame_done;
  logic accept;
  logic [3:0] f_cmd;
  logic [AW-1:0] f_addr;
  logic [DW-1:0] f_data;
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [DW-1:0] b_data;

  // a change counts only once the second and third stages agree
  for (genvar i = 0; i < SYNC_W; i++) begin : g_filt
    assign filt_nxt[i] = reset ? 1'b0 : ((s2_r[i] == s3_r[i]) ? s3_r[i] : filt_r[i]);
  end

  assign f_cmd = frame_r[CMD_MSB:CMD_LSB];
  assign f_addr = frame_r[FADDR_MSB:FADDR_LSB];
  assign f_data = frame_r[FDATA_MSB:FDATA_LSB];
  assign tclk_rise = filt_r[PIN_CLK] & ~tclk_d_r;
  assign sel_fall = ~filt_r[PIN_SEL] & tsel_d_r;
  // frames of the wrong length are dropped, so a glitched shift cannot program
  assign frame_done = sel_fall && (bits_r == FRAME_LEN);
  // commands arriving during a bank erase are ignored
  assign accept = frame_done && (st_r == UFR_IDLE);

  // the only write source is the programming port; fabric has none
  always_comb begin
    if (st_r == UFR_ERASE) begin
      wr_en = 1'b1; // [RL5]
      wr_addr = {bank_r, cnt_r}; // [RL1]
      wr_data = DW'(ERASED_BYTE);
    end else begin
      wr_en = accept && ((f_cmd == CMD_WRITE) || (f_cmd == CMD_WRITE_ENC)); // [RL5] [RL7]
      wr_addr = f_addr;
      // stand-in cipher: key byte mixed in on chip before storing
      wr_data = (f_cmd == CMD_WRITE_ENC) ? (f_data ^ key_r) : f_data; // [RL7]
    end
  end

  // serial shift-in, shift-out and read-back
  always_comb begin
    frame_nxt = frame_r;
    bits_nxt = bits_r;
    out_nxt = out_r;
    rdbk_pend_nxt = 1'b0;
    if (filt_r[PIN_SEL] && tclk_rise) begin
      frame_nxt = {frame_r[FRAME_BITS-2:0], filt_r[PIN_DIN]};
      // saturate one past a full frame so long frames are also dropped
      bits_nxt = (bits_r == FRAME_LEN + CNT_ONE) ? bits_r : bits_r + CNT_ONE;
      out_nxt = {out_r[DW-2:0], 1'b0};
    end else if (!filt_r[PIN_SEL]) begin
      bits_nxt = CNT_ZERO;
    end
    if (accept && (f_cmd == CMD_READ)) begin
      rdbk_pend_nxt = 1'b1; // [RL6]
    end
    if (rdbk_pend_r) begin
      out_nxt = b_data; // [RL6]
    end
    tap_dout_nxt = out_nxt[DW-1];
    if (reset) begin
      frame_nxt = '0;
      bits_nxt = CNT_ZERO;
      out_nxt = '0;
      rdbk_pend_nxt = 1'b0;
      tap_dout_nxt = 1'b0;
    end
  end

  // bank erase sequencer and key holder
  always_comb begin
    st_nxt = st_r;
    bank_nxt = bank_r;
    cnt_nxt = cnt_r;
    key_nxt = key_r;
    case (st_r)
      UFR_IDLE: begin
        if (accept && (f_cmd == CMD_ERASE)) begin
          st_nxt = UFR_ERASE; // [RL1] [RL7]
          bank_nxt = f_addr[BANK_MSB:BANK_LSB]; // [RL4]
          cnt_nxt = FIRST_BYTE;
        end
        if (accept && (f_cmd == CMD_LOAD_KEY)) begin
          key_nxt = f_data; // [RL7]
        end
      end
      UFR_ERASE: begin
        cnt_nxt = cnt_r + 4'h1;
        if (cnt_r == LAST_BYTE) begin
          st_nxt = UFR_IDLE;
        end
      end
      default: begin
        st_nxt = UFR_IDLE;
      end
    endcase
    if (reset) begin
      st_nxt = UFR_IDLE;
      bank_nxt = '0;
      cnt_nxt = FIRST_BYTE;
      key_nxt = '0;
    end
    busy_nxt = (st_nxt == UFR_ERASE);
  end

  always_ff @(posedge clk_sys) begin
    // first stage is read only by the second
    s1_r <= reset ? '0 : {tap_din, tap_sel, tap_clk};
    s2_r <= reset ? '0 : s1_r;
    s3_r <= reset ? '0 : s2_r;
    filt_r <= filt_nxt;
    tclk_d_r <= reset ? 1'b0 : filt_r[PIN_CLK];
    tsel_d_r <= reset ? 1'b0 : filt_r[PIN_SEL];
    frame_r <= frame_nxt;
    bits_r <= bits_nxt;
    out_r <= out_nxt;
    tap_dout_r <= tap_dout_nxt;
    rdbk_pend_r <= rdbk_pend_nxt;
    st_r <= st_nxt;
    bank_r <= bank_nxt;
    cnt_r <= cnt_nxt;
    key_r <= key_nxt;
    busy_r <= busy_nxt;
  end

  // fabric reads straight through the registered array port
  ufr_mem #(
    .AW(AW),
    .DW(DW)
  ) u_mem (
    .clk_sys(clk_sys),
    .reset(reset),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .a_addr(rd_addr), // [RL2] [RL8]
    .a_data(rd_data),
    .b_addr(f_addr),
    .b_data(b_data)
  );

  assign tap_dout = tap_dout_r;
  assign prog_busy = busy_r;

  AST_ERASE_SIXTEEN: assert property (@(posedge clk_sys) disable iff (reset) // [RL1]
    accept && (f_cmd == CMD_ERASE) |=> prog_busy [*8] ##1 prog_busy [*8] ##1 !prog_busy)
    else $error("bank erase did not span sixteen bytes");

  AST_ERASE_BANK: assert property (@(posedge clk_sys) disable iff (reset) // [RL4]
    accept && (f_cmd == CMD_ERASE)
    |=> wr_en && (wr_addr[BANK_MSB:BANK_LSB] == $past(f_addr[BANK_MSB:BANK_LSB]))
        && (wr_addr[BYTE_MSB:BYTE_LSB] == FIRST_BYTE) && (wr_data == ERASED_BYTE))
    else $error("erase started on wrong bank or byte");

  AST_WRITE_SOURCE: assert property (@(posedge clk_sys) disable iff (reset) // [RL5]
    wr_en |-> (st_r == UFR_ERASE) || frame_done)
    else $error("store written without a programming frame");

  AST_READBACK_LOAD: assert property (@(posedge clk_sys) disable iff (reset) // [RL6]
    accept && (f_cmd == CMD_READ) |=> ##1 (out_r == $past(b_data)) && (tap_dout == out_r[DW-1]))
    else $error("read-back byte not loaded into shift-out");

  AST_KEY_LOAD: assert property (@(posedge clk_sys) disable iff (reset) // [RL7]
    accept && (f_cmd == CMD_LOAD_KEY) |=> key_r == $past(f_data))
    else $error("key frame did not load the key");

  AST_ENC_WRITE: assert property (@(posedge clk_sys) disable iff (reset) // [RL7]
    accept && (f_cmd == CMD_WRITE_ENC) |-> wr_en && ((wr_data ^ f_data) == key_r))
    else $error("decrypted write did not use loaded key");

  AST_BUSY_REFUSE: assert property (@(posedge clk_sys) disable iff (reset) // [RL7]
    frame_done && (st_r == UFR_ERASE) |=> (bank_r == $past(bank_r)) && $stable(key_r))
    else $error("command acted on during bank erase");
endmodule

// [hw/ufr_pkg.sv]
// constants and types shared by the user flash store and its memory array
package ufr_pkg;
  // store organisation
  localparam int ADDR_W = 7;
  localparam int BANK_W = 3;
  localparam int BYTE_W = 4;
  localparam int DATA_W = 8;
  localparam int NUM_BANKS = 8;
  localparam int BANK_BITS = 128;
  localparam int BYTES_PER_BANK = BANK_BITS / DATA_W;
  localparam int DEPTH = NUM_BANKS * BYTES_PER_BANK;
  // address field positions
  localparam int BANK_MSB = 6;
  localparam int BANK_LSB = 4;
  localparam int BYTE_MSB = 3;
  localparam int BYTE_LSB = 0;
  // erased flash reads as all ones
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] LAST_BYTE = 4'hf;
  localparam logic [3:0] FIRST_BYTE = 4'h0;
  // programming-port frame layout, shifted in msb first
  localparam int FRAME_BITS = 24;
  localparam logic [4:0] FRAME_LEN = 5'h18;
  localparam logic [4:0] CNT_ZERO = 5'h00;
  localparam logic [4:0] CNT_ONE = 5'h01;
  localparam int CMD_MSB = 23;
  localparam int CMD_LSB = 20;
  localparam int FADDR_MSB = 19;
  localparam int FADDR_LSB = 13;
  localparam int FDATA_MSB = 7;
  localparam int FDATA_LSB = 0;
  // programming-port commands
  localparam logic [3:0] CMD_ERASE = 4'h1;
  localparam logic [3:0] CMD_WRITE = 4'h2;
  localparam logic [3:0] CMD_WRITE_ENC = 4'h3;
  localparam logic [3:0] CMD_LOAD_KEY = 4'h4;
  localparam logic [3:0] CMD_READ = 4'h5;
  // pin synchroniser: bit 0 clock, bit 1 select, bit 2 data
  localparam int SYNC_W = 3;
  localparam int PIN_CLK = 0;
  localparam int PIN_SEL = 1;
  localparam int PIN_DIN = 2;
  typedef enum logic [0:0] {UFR_IDLE, UFR_ERASE} ufr_state_t;
endpackage

// [hw/ufr_mem.sv]
// byte-wide store array with one write port and two registered read ports
`timescale 1ns/1ps
module ufr_mem import ufr_pkg::*; #(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // write port, programming side only
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  // fabric read port
  input wire logic [AW-1:0] a_addr,
  output logic [DW-1:0] a_data,
  // programming read-back port
  input wire logic [AW-1:0] b_addr,
  output logic [DW-1:0] b_data
);
  logic [DW-1:0] mem_r [0:(1<<AW)-1];
  logic [DW-1:0] a_data_r;
  logic [DW-1:0] b_data_r;
  logic [DW-1:0] a_data_nxt;
  logic [DW-1:0] b_data_nxt;
  // assertion helper: cells written since reset; unprogrammed cells read unknown
  logic [(1<<AW)-1:0] known_r;
  logic [(1<<AW)-1:0] known_nxt;

  // a read colliding with a write returns the old byte
  always_comb begin
    a_data_nxt = reset ? DW'(RESET_BYTE) : mem_r[a_addr]; // [RL2] [RL4]
    b_data_nxt = reset ? DW'(RESET_BYTE) : mem_r[b_addr]; // [RL6]
    known_nxt = known_r;
    if (wr_en) begin
      known_nxt[wr_addr] = 1'b1;
    end
    if (reset) begin
      known_nxt = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    a_data_r <= a_data_nxt;
    b_data_r <= b_data_nxt;
    known_r <= known_nxt;
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
  end

  assign a_data = a_data_r;
  assign b_data = b_data_r;

  AST_FABRIC_ONE_EDGE: assert property (@(posedge clk_sys) disable iff (reset) // [RL8]
    known_r[a_addr] |=> a_data == $past(mem_r[a_addr]))
    else $error("fabric byte not returned one edge after address");

  AST_FABRIC_ADDR_DECODE: assert property (@(posedge clk_sys) disable iff (reset) // [RL4]
    $past(wr_en) && ($past(wr_addr) == a_addr) && $stable(a_addr)
    |=> a_data == $past(wr_data, 2))
    else $error("byte written at bank and index not read back there");
endmodule

// [test/ufr_fabric_model.sv]
// fabric-side reader standing in front of the store's read port
`timescale 1ns/1ps
module ufr_fabric_model import ufr_pkg::*; (
  // clock
  input wire logic clk_sys,
  // address the bench wants read next
  input wire logic [ADDR_W-1:0] want_addr,
  // toward the store
  output logic [ADDR_W-1:0] rd_addr
);
  // moves just after a rising edge, then held a whole cycle for capture
  always @(posedge clk_sys) begin
    rd_addr <= want_addr;
  end
endmodule

// [test/testbench.sv]
// self-checking bench for the user flash byte store
`timescale 1ns/1ps
module testbench import ufr_pkg::*; ;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [6:0] want_addr = 7'h00;
  logic [6:0] rd_addr;
  logic [7:0] rd_data;
  logic tap_clk = 1'b0;
  logic tap_sel = 1'b0;
  logic tap_din = 1'b0;
  logic tap_dout;
  logic prog_busy;
  logic [7:0] img [128];
  logic [23:0] got = 24'h000000;
  int mismatches = 0;
  int num_checks = 0;
  int busy_len = 0;

  always #5 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    if (prog_busy === 1'b1) busy_len++;
  end

  ufr_fabric_model fab (.clk_sys(clk_sys), .want_addr(want_addr), .rd_addr(rd_addr));

  ufr_top dut (.clk_sys(clk_sys), .reset(reset), .rd_addr(rd_addr), .rd_data(rd_data),
    .tap_clk(tap_clk), .tap_sel(tap_sel), .tap_din(tap_din), .tap_dout(tap_dout),
    .prog_busy(prog_busy));

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // pins held four cycles per phase so the three-flop filter sees every level
  task automatic send(input logic [23:0] f, input int n);
    tap_sel = 1'b1;
    for (int i = 0; i < n; i++) begin
      tap_din = (i < 24) ? f[23 - i] : 1'b0;
      tick(4);
      got = {got[22:0], tap_dout};
      tap_clk = 1'b1;
      tick(4);
      tap_clk = 1'b0;
    end
    tick(4);
    tap_sel = 1'b0;
    tick(8);
  endtask

  task automatic prog(input logic [3:0] cmd, input logic [6:0] a, input logic [7:0] d);
    send({cmd, a, 5'h00, d}, 24);
  endtask

  task automatic erase(input logic [2:0] b);
    busy_len = 0;
    prog(CMD_ERASE, {b, 4'h0}, 8'h00);
    for (int k = 0; k < 40 && prog_busy !== 1'b0; k++) tick(1);
    check("busy_len", 8'(busy_len), 8'h10);
    for (int k = 0; k < 16; k++) img[{b, 4'h0} + k] = ERASED_BYTE;
  endtask

  // a new address every cycle; each byte judged two falling edges later
  task automatic rd_all();
    for (int i = 0; i < 130; i++) begin
      if (i >= 2) check("rd_data", rd_data, img[i - 2]);
      if (i < 128) want_addr = 7'(i);
      tick(1);
    end
  endtask

  task automatic t_reset();
    check("rd_data", rd_data, RESET_BYTE);
    check("busy", {7'h00, prog_busy}, 8'h00);
    check("tap_dout", {7'h00, tap_dout}, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_erase_all();
    for (int b = 0; b < 8; b++) erase(3'(b));
    rd_all();
    $display("test erase done");
  endtask

  // distinct byte everywhere, then one bank erased must leave the others alone
  task automatic t_write();
    for (int a = 0; a < 128; a++) begin
      prog(CMD_WRITE, 7'(a), 8'(a * 7 + 3));
      img[a] = 8'(a * 7 + 3);
    end
    rd_all();
    erase(3'h5);
    rd_all();
    $display("test write done");
  endtask

  task automatic t_enc();
    prog(CMD_LOAD_KEY, 7'h00, 8'ha5);
    prog(CMD_WRITE_ENC, 7'h42, 8'h3c);
    img[7'h42] = 8'h99;
    rd_all();
    $display("test decrypt done");
  endtask

  // byte comes out msb first during the following frame
  task automatic t_readback();
    prog(CMD_READ, 7'h42, 8'h00);
    send(24'h000000, 24);
    check("tap_byte", got[23:16], img[7'h42]);
    $display("test readback done");
  endtask

  // frames one bit short and one bit long are dropped whole
  task automatic t_refuse();
    send({CMD_WRITE, 7'h10, 5'h00, 8'h00}, 23);
    send({CMD_WRITE, 7'h11, 5'h00, 8'h00}, 25);
    rd_all();
    $display("test refuse done");
  endtask

  initial begin
    tick(7);
    t_reset();
    tick(1);
    reset = 1'b0;
    tick(1);
    t_erase_all();
    t_write();
    t_enc();
    t_readback();
    t_refuse();
    final_report();
  end

  // the full run needs about 300 us
  initial begin
    #600us;
    mismatches++;
    final_report();
  end
endmodule
